// >>> core/reset_and_power_control.sv
// reset combining, start-up delay, sleep gating and clock gating
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: sleep instruction sleeps only when the sleep permit bit is one.
// R2: software sets sleep permit just before sleep, clears it on wake.
// R3: off bit needs unlock write, then off-only write within four cycles.
// R4: off bit becomes active three cycles after set, clears three later.
// R5: detector off in sleep only if sleep happens while off bit active.
// R6: off bit sits at bit 6, unlock bit at bit 5 of mcu control.
// R7: a one in a clock gate bit stops that peripheral's clock.
// R8: timer two gate acts only while its asynchronous select is zero.
// R9: gated timers resume frozen state; serial blocks need reinitialising.
// R10: converter disabled before gating; comparator loses its input mux.
// R11: reset loads initial register values; execution restarts at vector.
// R12: ports return to initial state at once, with no clock needed.
// R13: delay counter stretches internal reset after all sources release.
// R14: internal reset combines power-on, pin, watchdog, brown-out, test.
// R15: low reset pin asserts reset; release after start-up timeout.
// R16: power-on reset reasserts at once; release goes through counter.
// R17: enabled brown-out asserts at once; release after start-up timeout.
// R18: watchdog gives one-cycle pulse; timeout counted from its end.
// R19: bandgap on when detector enabled, comparator select, or converter.
// R20: software waits reference start-up before using its outputs.
// R21: sleep select codes pick idle to extended standby; 4 and 5 reserved.
// R22: watchdog flag set by watchdog reset; cleared by power-on or zero.
// R23: delay counter restarts whenever any source reasserts while counting.
module reset_and_power_control #(
   parameter int          TOUT_W      = 16,     // delay counter width
   parameter logic [15:0] TOUT_FAST   = 16'h0010, // short start-up timeout
   parameter logic [15:0] TOUT_SLOW   = 16'h1000  // long start-up timeout
) (
   input  wire logic                     core_clk,       // system clock
   input  wire logic                     rst_n,          // power-on, async
   input  wire logic                     reset_pin_n,    // reset pin, low
   input  wire rst_pwr_pkg::reset_src_t  src,            // supply, watchdog
   input  wire logic                     bod_enabled,    // detector fused on
   input  wire logic [1:0]               startup_time_select, // fuse
   input  wire logic [3:0]               clock_source_select, // fuse
   input  wire logic                     sleep_instr,    // cpu sleep pulse
   input  wire logic                     timer_two_async_select, // async
   input  wire logic                     comparator_bandgap_select, // ref
   input  wire logic                     converter_enabled, // adc on
   input  wire rst_pwr_pkg::reg_req_t    req,            // register port
   output logic [7:0]                    rdata,          // read data
   output logic                          ports_reset,    // port reset, async
   output logic                          core_reset,     // stretched reset
   output logic                          sleep_go,       // enter sleep pulse
   output rst_pwr_pkg::sleep_mode_t      sleep_mode,     // selected mode
   output logic                          bod_off_in_sleep, // detector off
   output rst_pwr_pkg::clk_enable_t      clk_en,         // clock enables
   output logic                          comp_mux_allowed, // comparator mux
   output logic                          bandgap_enable  // reference on
);

   // synchronised pin and supply levels
   logic [1:0] pin_sync_r;
   logic [1:0] por_sync_r;
   logic [1:0] bor_sync_r;
   logic [1:0] wdt_sync_r;
   logic       wdt_prev_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_r <= 2'h0;
         por_sync_r <= 2'h3;
         bor_sync_r <= 2'h0;
         wdt_sync_r <= 2'h0;
         wdt_prev_r <= 1'b0;
      end else begin
         pin_sync_r <= {pin_sync_r[0], reset_pin_n};
         por_sync_r <= {por_sync_r[0], src.power_low};
         bor_sync_r <= {bor_sync_r[0], src.brownout_low & bod_enabled};
         wdt_sync_r <= {wdt_sync_r[0], src.watchdog_pulse};
         wdt_prev_r <= wdt_sync_r[1];
      end
   end

   // raw combination drives ports without needing a clock
   wire brownout_raw = src.brownout_low & bod_enabled;                // R17
   wire test_reset;
   assign ports_reset = !rst_n | !reset_pin_n | src.power_low |
                        brownout_raw | src.watchdog_pulse | test_reset; // R12

   // synchronised sources that feed the delay counter
   wire pin_low   = !pin_sync_r[1];                                   // R15
   wire por_low   = por_sync_r[1];                                    // R16
   wire bor_low   = bor_sync_r[1];                                    // R17
   wire wdt_pulse = wdt_sync_r[1];                                    // R18
   wire wdt_fall  = wdt_prev_r & !wdt_sync_r[1];
   wire any_src   = pin_low | por_low | bor_low | wdt_pulse | test_reset; // R14

   // start-up timeout choice from fuse settings
   wire [TOUT_W-1:0] tout_cycles =
      (startup_time_select == 2'h0 && clock_source_select[3] == 1'b0)
         ? TOUT_W'(TOUT_FAST) : TOUT_W'(TOUT_SLOW);                   // R13

   logic [TOUT_W-1:0] delay_cnt_r;
   logic              core_reset_r;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         delay_cnt_r  <= '0;
         core_reset_r <= 1'b1;
      end else if (any_src || src.watchdog_pulse) begin               // R18
         delay_cnt_r  <= '0;                                          // R23
         core_reset_r <= 1'b1;
      end else if (core_reset_r) begin
         if (delay_cnt_r >= tout_cycles - TOUT_W'(1)) begin
            core_reset_r <= 1'b0;                                     // R13
         end else begin
            delay_cnt_r <= delay_cnt_r + TOUT_W'(1);
         end
      end
   end
   // async assert, clocked release through the counter
   assign core_reset = core_reset_r | ports_reset;                    // R16

   // register state
   logic [7:0]  sleep_ctrl_r;
   logic [7:0]  clock_gate_r;
   logic [4:0]  cause_r;
   logic        test_reset_r;
   logic        brownout_sleep_off_r;
   logic        brownout_sleep_off_unlock_r;
   rst_pwr_pkg::brownout_sleep_off_state_t brownout_sleep_off_state_r;
   logic [2:0]  unlock_cnt_r;
   logic [2:0]  brownout_sleep_off_cnt_r;
   logic        bod_off_r;

   assign test_reset = test_reset_r;                                  // R14

   // address decode
   wire sel_sleep = req.addr == rst_pwr_pkg::OFS_SLEEP_CTRL;
   wire sel_mcu   = req.addr == rst_pwr_pkg::OFS_MCU_CONTROL;
   wire sel_gate  = req.addr == rst_pwr_pkg::OFS_CLOCK_GATE;
   wire sel_cause = req.addr == rst_pwr_pkg::OFS_RESET_CAUSE;
   wire sel_test  = req.addr == rst_pwr_pkg::OFS_TEST_RESET;
   wire wr_mcu    = req.wr & sel_mcu;
   wire wd_off    = req.wdata[rst_pwr_pkg::BOD_SLEEP_OFF_BIT];        // R6
   wire wd_unlock = req.wdata[rst_pwr_pkg::BOD_UNLOCK_BIT];           // R6
   wire arm_write = wr_mcu & wd_off & wd_unlock;                      // R3
   wire set_write = wr_mcu & wd_off & !wd_unlock & (unlock_cnt_r != 3'h0);
   wire cause_wr  = req.wr & sel_cause;

   // sleep control and clock gate, cleared while reset is held
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_ctrl_r <= rst_pwr_pkg::RESET_BYTE;                     // R11
         clock_gate_r <= rst_pwr_pkg::RESET_BYTE;
         test_reset_r <= 1'b0;
      end else if (core_reset_r) begin
         sleep_ctrl_r <= rst_pwr_pkg::RESET_BYTE;                     // R11
         clock_gate_r <= rst_pwr_pkg::RESET_BYTE;
         if (req.wr && sel_test) begin
            test_reset_r <= req.wdata[0];
         end
      end else begin
         if (req.wr && sel_sleep) begin
            sleep_ctrl_r <= {4'h0, req.wdata[3:0]};
         end
         if (req.wr && sel_gate) begin
            clock_gate_r <= req.wdata;                                // R7
         end
         if (req.wr && sel_test) begin
            test_reset_r <= req.wdata[0];
         end
      end
   end

   // timed unlock window and sleep-off bit sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_cnt_r  <= 3'h0;
         brownout_sleep_off_unlock_r <= 1'b0;
         brownout_sleep_off_r        <= 1'b0;
         brownout_sleep_off_state_r  <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_OFF;
         brownout_sleep_off_cnt_r    <= 3'h0;
      end else if (core_reset_r) begin
         unlock_cnt_r  <= 3'h0;
         brownout_sleep_off_unlock_r <= 1'b0;
         brownout_sleep_off_r        <= 1'b0;
         brownout_sleep_off_state_r  <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_OFF;
         brownout_sleep_off_cnt_r    <= 3'h0;
      end else begin
         if (arm_write) begin
            unlock_cnt_r  <= rst_pwr_pkg::UNLOCK_WINDOW_CYC;          // R3
            brownout_sleep_off_unlock_r <= 1'b1;
         end else if (unlock_cnt_r != 3'h0) begin
            unlock_cnt_r  <= unlock_cnt_r - 3'h1;
            brownout_sleep_off_unlock_r <= (unlock_cnt_r != 3'h1) & !set_write;
         end else begin
            brownout_sleep_off_unlock_r <= 1'b0;
         end
         case (brownout_sleep_off_state_r)
            rst_pwr_pkg::BROWNOUT_SLEEP_OFF_OFF: begin
               if (set_write) begin
                  brownout_sleep_off_r       <= 1'b1;                               // R3
                  brownout_sleep_off_cnt_r   <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_DELAY_CYC;
                  brownout_sleep_off_state_r <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_PENDING;
               end
            end
            rst_pwr_pkg::BROWNOUT_SLEEP_OFF_PENDING: begin
               if (brownout_sleep_off_cnt_r == 3'h1) begin
                  brownout_sleep_off_cnt_r   <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_HOLD_CYC;         // R4
                  brownout_sleep_off_state_r <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_ACTIVE;
               end else begin
                  brownout_sleep_off_cnt_r <= brownout_sleep_off_cnt_r - 3'h1;
               end
            end
            rst_pwr_pkg::BROWNOUT_SLEEP_OFF_ACTIVE: begin
               if (brownout_sleep_off_cnt_r == 3'h1) begin
                  brownout_sleep_off_r       <= 1'b0;                               // R4
                  brownout_sleep_off_state_r <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_OFF;
               end else begin
                  brownout_sleep_off_cnt_r <= brownout_sleep_off_cnt_r - 3'h1;
               end
            end
            default: brownout_sleep_off_state_r <= rst_pwr_pkg::BROWNOUT_SLEEP_OFF_OFF;
         endcase
      end
   end

   wire brownout_sleep_off_active = brownout_sleep_off_state_r == rst_pwr_pkg::BROWNOUT_SLEEP_OFF_ACTIVE;

   // sleep entry
   wire [2:0] sel_code = sleep_ctrl_r[rst_pwr_pkg::SLEEP_SELECT_LSB +: 3];
   wire       sel_rsvd = sel_code == 3'h4 || sel_code == 3'h5;        // R21
   wire       sleep_ok = sleep_instr & sleep_ctrl_r[0] & !sel_rsvd &
                         !core_reset_r;                                // R1

   logic sleep_go_r;
   logic sleeping_r;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_go_r <= 1'b0;
         sleeping_r <= 1'b0;
         bod_off_r  <= 1'b0;
      end else begin
         sleep_go_r <= sleep_ok;                                      // R1
         if (sleep_ok) begin
            sleeping_r <= 1'b1;
            bod_off_r  <= brownout_sleep_off_active;                                // R5
         end else if (!sleep_ctrl_r[0] || core_reset_r) begin
            sleeping_r <= 1'b0;
            bod_off_r  <= 1'b0;
         end
      end
   end

   assign sleep_go         = sleep_go_r;
   assign sleep_mode       = rst_pwr_pkg::sleep_mode_t'(sel_code);    // R21
   assign bod_off_in_sleep = bod_off_r & sleeping_r;                  // R5

   // clock gating
   wire timer_two_gated = clock_gate_r[6] & !timer_two_async_select;  // R8
   // a stopped clock freezes state, so restoring it resumes there
   assign clk_en = rst_pwr_pkg::clk_enable_t'(~{clock_gate_r[7],
                   timer_two_gated, clock_gate_r[5:0]});              // R7 R9
   assign comp_mux_allowed   = !clock_gate_r[0];                      // R10

   assign bandgap_enable = bod_enabled | comparator_bandgap_select |
                           converter_enabled;                         // R19

   // reset cause flags; set wins over a software clear
   wire [4:0] cause_set = {test_reset, wdt_fall, bor_low, pin_low, por_low};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_r <= 5'h01;
      end else if (por_low) begin
         cause_r <= 5'h01;                                            // R22
      end else begin
         cause_r <= (cause_wr ? (cause_r & req.wdata[4:0]) : cause_r) |
                    cause_set;                                        // R22
      end
   end

   // read mux
   wire [7:0] mcu_rd = {1'b0, brownout_sleep_off_r, brownout_sleep_off_unlock_r, 5'h00};
   wire [7:0] rd_val =
      sel_sleep ? sleep_ctrl_r :
      sel_mcu   ? mcu_rd :
      sel_gate  ? clock_gate_r :
      sel_cause ? {3'h0, cause_r} :
      sel_test  ? {7'h00, test_reset_r} : 8'h00;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 8'h00;
      end else begin
         rdata <= req.rd ? rd_val : 8'h00;
      end
   end

endmodule // reset_and_power_control
`default_nettype wire

// >>> core/rst_pwr_pkg.sv
// constants and carrier types for the reset and power control block
package rst_pwr_pkg;
   // register offsets on the plain register port
   localparam logic [3:0] OFS_SLEEP_CTRL  = 4'h0;
   localparam logic [3:0] OFS_MCU_CONTROL = 4'h1;
   localparam logic [3:0] OFS_CLOCK_GATE  = 4'h2;
   localparam logic [3:0] OFS_RESET_CAUSE = 4'h3;
   localparam logic [3:0] OFS_TEST_RESET  = 4'h4;
   // sleep control field positions
   localparam int SLEEP_PERMIT_BIT  = 0;
   localparam int SLEEP_SELECT_LSB  = 1;
   // mcu control field positions
   localparam int BOD_SLEEP_OFF_BIT = 6;
   localparam int BOD_UNLOCK_BIT    = 5;
   // clock gate bit positions
   localparam int GATE_TWO_WIRE_BIT    = 7;
   localparam int GATE_TIMER_TWO_BIT   = 6;
   localparam int GATE_TIMER_ZERO_BIT  = 5;
   localparam int GATE_SERIAL_ONE_BIT  = 4;
   localparam int GATE_TIMER_ONE_BIT   = 3;
   localparam int GATE_SPI_BIT         = 2;
   localparam int GATE_SERIAL_ZERO_BIT = 1;
   localparam int GATE_CONVERTER_BIT   = 0;
   // reset cause bit positions
   localparam int CAUSE_POWER_ON_BIT = 0;
   localparam int CAUSE_PIN_BIT      = 1;
   localparam int CAUSE_BROWNOUT_BIT = 2;
   localparam int CAUSE_WATCHDOG_BIT = 3;
   localparam int CAUSE_TEST_BIT     = 4;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // timing of the brown-out sleep-off sequence, in clock cycles
   localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
   localparam logic [2:0] BROWNOUT_SLEEP_OFF_DELAY_CYC    = 3'h3;
   localparam logic [2:0] BROWNOUT_SLEEP_OFF_HOLD_CYC     = 3'h3;

   typedef enum logic [2:0] {
      SLEEP_IDLE      = 3'h0,
      SLEEP_ADC_NR    = 3'h1,
      SLEEP_POWER_DN  = 3'h2,
      SLEEP_POWER_SV  = 3'h3,
      SLEEP_RSVD_4    = 3'h4,
      SLEEP_RSVD_5    = 3'h5,
      SLEEP_STANDBY   = 3'h6,
      SLEEP_EXT_STBY  = 3'h7
   } sleep_mode_t;

   typedef enum logic [1:0] {
      BROWNOUT_SLEEP_OFF_OFF,
      BROWNOUT_SLEEP_OFF_PENDING,
      BROWNOUT_SLEEP_OFF_ACTIVE
   } brownout_sleep_off_state_t;

   // register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // raw reset source levels, all active high
   typedef struct packed {
      logic power_low;
      logic brownout_low;
      logic watchdog_pulse;
   } reset_src_t;

   // per-peripheral clock enables
   typedef struct packed {
      logic two_wire;
      logic timer_two;
      logic timer_zero;
      logic serial_one;
      logic timer_one;
      logic spi;
      logic serial_zero;
      logic converter;
   } clk_enable_t;
endpackage : rst_pwr_pkg

// >>> verification/reset_and_power_control_asserts.sv
// port assertions for the reset and power control block
`timescale 1ns/1ns
`default_nettype none
module reset_and_power_control_asserts (
   input wire logic                     core_clk,    // clock
   input wire logic                     rst_n,       // reset
   input wire logic                     reset_pin_n, // pin
   input wire rst_pwr_pkg::reset_src_t  src,         // sources
   input wire logic                     bod_enabled, // detector
   input wire logic                     sleep_instr, // sleep
   input wire logic                     timer_two_async_select, // async
   input wire logic                     comparator_bandgap_select, // ref
   input wire logic                     converter_enabled, // adc
   input wire rst_pwr_pkg::reg_req_t    req,         // registers
   input wire logic                     ports_reset, // port reset
   input wire logic                     core_reset,  // core reset
   input wire logic                     sleep_go,    // sleep
   input wire rst_pwr_pkg::sleep_mode_t sleep_mode,  // mode
   input wire logic                     bod_off_in_sleep, // bod off
   input wire rst_pwr_pkg::clk_enable_t clk_en,      // enables
   input wire logic                     comp_mux_allowed, // mux
   input wire logic                     bandgap_enable // reference
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_pin_reset_now: assert property (
      !reset_pin_n |-> ports_reset && core_reset)
      else $error("pin low without reset");
   chk_power_low_now: assert property (
      src.power_low |-> ports_reset && core_reset)
      else $error("supply low without reset");
   chk_brownout_now: assert property (
      src.brownout_low && bod_enabled |-> ports_reset && core_reset)
      else $error("brown-out without reset");
   chk_release_stretch: assert property (
      $fell(ports_reset) |-> core_reset[*8])
      else $error("core reset released early");
   chk_watchdog_stretch: assert property (
      $fell(src.watchdog_pulse) |-> ##3 core_reset[*8])
      else $error("watchdog reset not stretched");
   chk_sleep_cause: assert property (
      sleep_go |-> $past(sleep_instr) && !($past(sleep_mode) inside
         {rst_pwr_pkg::SLEEP_RSVD_4, rst_pwr_pkg::SLEEP_RSVD_5}))
      else $error("sleep without valid request");
   chk_sleep_pulse: assert property (
      sleep_go |=> !sleep_go)
      else $error("sleep pulse too long");
   chk_timer_two_async: assert property (
      timer_two_async_select |-> clk_en.timer_two)
      else $error("timer two gated in async mode");
   chk_adc_mux_block: assert property (
      !clk_en.converter |-> !comp_mux_allowed)
      else $error("mux allowed while converter gated");
   chk_bandgap_or: assert property (
      !bod_off_in_sleep |-> bandgap_enable == (bod_enabled
         | comparator_bandgap_select | converter_enabled))
      else $error("bandgap enable wrong");
   chk_gate_write: assert property (
      req.wr && req.addr == rst_pwr_pkg::OFS_CLOCK_GATE && !core_reset
      |=> clk_en.converter == !$past(req.wdata[0])
         && clk_en.two_wire == !$past(req.wdata[7]))
      else $error("clock gate write not applied");
endmodule // reset_and_power_control_asserts
bind reset_and_power_control reset_and_power_control_asserts u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
   .src(src), .bod_enabled(bod_enabled), .sleep_instr(sleep_instr),
   .timer_two_async_select(timer_two_async_select),
   .comparator_bandgap_select(comparator_bandgap_select),
   .converter_enabled(converter_enabled), .req(req),
   .ports_reset(ports_reset), .core_reset(core_reset),
   .sleep_go(sleep_go), .sleep_mode(sleep_mode),
   .bod_off_in_sleep(bod_off_in_sleep), .clk_en(clk_en),
   .comp_mux_allowed(comp_mux_allowed), .bandgap_enable(bandgap_enable));
`default_nettype wire

// >>> verification/reset_source_model.sv
// far-side model: reset pin, supply monitors, watchdog, cpu sleep
`timescale 1ns/1ns
`default_nettype none
module reset_source_model (
   input  wire logic               core_clk,    // clock
   input  wire logic               lvl_pin,     // hold pin low
   input  wire logic               lvl_power,   // supply low
   input  wire logic               lvl_brown,   // brown-out low
   input  wire logic               fire_wd,     // watchdog expiry
   input  wire logic               fire_sleep,  // sleep request
   output logic                    reset_pin_n, // reset pin
   output rst_pwr_pkg::reset_src_t src,         // source levels
   output logic                    sleep_instr  // sleep pulse
);
   logic wd_q;
   logic wd_pulse;
   // one-cycle pulse per expiry
   always_ff @(posedge core_clk) begin
      wd_q     <= fire_wd;
      wd_pulse <= fire_wd & ~wd_q;
   end
   assign reset_pin_n = ~lvl_pin;
   assign src = '{power_low: lvl_power, brownout_low: lvl_brown,
                  watchdog_pulse: wd_pulse};
   assign sleep_instr = fire_sleep;
endmodule // reset_source_model
`default_nettype wire

// >>> verification/testbench.sv
// self-checking bench for the reset and power control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   typedef struct packed {
      logic [3:0] a;
      logic [7:0] d;
      logic       as;
      logic [7:0] rd;
      logic [7:0] ce;
   } row_t;
   logic core_clk, rst_n, bod_enabled, async2, cbg, conv;
   logic lvl_pin, lvl_power, lvl_brown, fire_wd, fire_sleep;
   logic reset_pin_n, sleep_instr, ports_reset, core_reset;
   logic sleep_go, bod_off, mux, bg;
   logic [7:0] rdata, got;
   rst_pwr_pkg::reset_src_t  src;
   rst_pwr_pkg::reg_req_t    req;
   rst_pwr_pkg::sleep_mode_t sleep_mode;
   rst_pwr_pkg::clk_enable_t clk_en;
   int n_fail = 0;
   int n_checks = 0;
   int n;
   row_t rows [8] = '{
      '{rst_pwr_pkg::OFS_CLOCK_GATE, 8'hFF, 1'b0, 8'hFF, 8'h00},
      '{rst_pwr_pkg::OFS_CLOCK_GATE, 8'hFF, 1'b1, 8'hFF, 8'h40},
      '{rst_pwr_pkg::OFS_CLOCK_GATE, 8'h01, 1'b0, 8'h01, 8'hFE},
      '{rst_pwr_pkg::OFS_CLOCK_GATE, 8'h80, 1'b0, 8'h80, 8'h7F},
      '{rst_pwr_pkg::OFS_SLEEP_CTRL, 8'hFE, 1'b0, 8'h0E, 8'h7F},
      '{4'hF, 8'h55, 1'b0, 8'h00, 8'h7F},
      '{rst_pwr_pkg::OFS_RESET_CAUSE, 8'h00, 1'b0, 8'h00, 8'h7F},
      '{rst_pwr_pkg::OFS_CLOCK_GATE, 8'h00, 1'b1, 8'h00, 8'hFF}};

   reset_source_model u_src (
      .core_clk(core_clk), .lvl_pin(lvl_pin), .lvl_power(lvl_power),
      .lvl_brown(lvl_brown), .fire_wd(fire_wd), .fire_sleep(fire_sleep),
      .reset_pin_n(reset_pin_n), .src(src), .sleep_instr(sleep_instr));
   reset_and_power_control #(
      .TOUT_FAST(16'h0010),
      .TOUT_SLOW(16'h0010)
   ) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
      .src(src), .bod_enabled(bod_enabled),
      .startup_time_select(2'h0), .clock_source_select(4'h0),
      .sleep_instr(sleep_instr), .timer_two_async_select(async2),
      .comparator_bandgap_select(cbg), .converter_enabled(conv),
      .req(req), .rdata(rdata), .ports_reset(ports_reset),
      .core_reset(core_reset), .sleep_go(sleep_go),
      .sleep_mode(sleep_mode), .bod_off_in_sleep(bod_off),
      .clk_en(clk_en), .comp_mux_allowed(mux), .bandgap_enable(bg));

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      req <= '0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      req <= '0;
      #1 d = rdata;
      @(posedge core_clk);
   endtask
   task automatic wait_rel(output int cnt);
      cnt = 0;
      while (core_reset !== 1'b0 && cnt < 200) begin
         @(posedge core_clk);
         #1 cnt++;
      end
      @(posedge core_clk);
   endtask
   task automatic src_reset(input int kind);
      int cnt;
      case (kind)
         0: lvl_pin <= 1'b1;
         1: lvl_power <= 1'b1;
         2: lvl_brown <= 1'b1;
         default: fire_wd <= 1'b1;
      endcase
      repeat (4) @(posedge core_clk);
      #1 chk8({6'h0, ports_reset, core_reset}, {6'h0, kind < 3, 1'b1});
      @(posedge core_clk);
      {lvl_pin, lvl_power, lvl_brown, fire_wd} <= '0;
      wait_rel(cnt);
      chk8(8'(cnt >= 13 && cnt <= 26), 8'h01);
   endtask
   task automatic sleep_try(input logic [3:0] ctl, input logic e);
      wr(rst_pwr_pkg::OFS_SLEEP_CTRL, {4'h0, ctl});
      fire_sleep <= 1'b1;
      @(posedge core_clk);
      fire_sleep <= 1'b0;
      #1 chk8({5'h0, sleep_mode}, {5'h0, ctl[3:1]});
      chk8({7'h0, sleep_go}, {7'h0, e});
      @(posedge core_clk);
      wr(rst_pwr_pkg::OFS_SLEEP_CTRL, 8'h00);
   endtask
   // unlock, gap, off-only write, k cycles, then sleep
   task automatic brownout_sleep_off(input int gap, input int k, input logic e);
      wr(rst_pwr_pkg::OFS_SLEEP_CTRL, 8'h05);
      wr(rst_pwr_pkg::OFS_MCU_CONTROL, 8'h60);
      repeat (gap) @(posedge core_clk);
      wr(rst_pwr_pkg::OFS_MCU_CONTROL, 8'h40);
      repeat (k) @(posedge core_clk);
      fire_sleep <= 1'b1;
      @(posedge core_clk);
      fire_sleep <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk8({7'h0, bod_off}, {7'h0, e});
      @(posedge core_clk);
      wr(rst_pwr_pkg::OFS_SLEEP_CTRL, 8'h00);
      repeat (8) @(posedge core_clk);
   endtask
   task automatic complete_run;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
   initial begin
      {rst_n, bod_enabled, async2, cbg, conv} = '0;
      {lvl_pin, lvl_power, lvl_brown, fire_wd, fire_sleep} = '0;
      req = '0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      wait_rel(n);
      chk8(8'(n >= 16 && n <= 24), 8'h01);
      for (int i = 0; i < 5; i++) begin
         rd(4'(i), got);
         chk8(got, (i == 3) ? 8'h01 : rst_pwr_pkg::RESET_BYTE);
      end
      for (int i = 0; i < 8; i++) begin
         async2 <= rows[i].as;
         cbg <= rows[i].as;
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, got);
         chk8(got, rows[i].rd);
         chk8(clk_en, rows[i].ce);
         chk8({6'h0, mux, bg}, {6'h0, rows[i].ce[0], rows[i].as});
      end
      for (int m = 0; m < 8; m++)
         sleep_try({m[2:0], 1'b1}, logic'(m != 4 && m != 5));
      sleep_try(4'h4, 1'b0);
      lvl_brown <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1 chk8({7'h0, core_reset}, 8'h00);
      @(posedge core_clk);
      lvl_brown <= 1'b0;
      bod_enabled <= 1'b1;
      @(posedge core_clk);
      for (int k = 0; k < 4; k++)
         src_reset(k);
      rd(rst_pwr_pkg::OFS_RESET_CAUSE, got);
      chk8(got & 8'h08, 8'h08);
      wr(rst_pwr_pkg::OFS_RESET_CAUSE, 8'h00);
      rd(rst_pwr_pkg::OFS_RESET_CAUSE, got);
      chk8(got & 8'h08, 8'h00);
      lvl_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      lvl_pin <= 1'b0;
      repeat (8) @(posedge core_clk);
      src_reset(1);
      wr(rst_pwr_pkg::OFS_TEST_RESET, 8'h01);
      #1 chk8({7'h0, core_reset}, 8'h01);
      @(posedge core_clk);
      wr(rst_pwr_pkg::OFS_TEST_RESET, 8'h00);
      wait_rel(n);
      chk8(8'(n >= 13 && n <= 20), 8'h01);
      brownout_sleep_off(0, 0, 1'b0);
      brownout_sleep_off(0, 2, 1'b1);
      brownout_sleep_off(0, 6, 1'b0);
      brownout_sleep_off(3, 2, 1'b0);
      wr(rst_pwr_pkg::OFS_MCU_CONTROL, 8'h60);
      rd(rst_pwr_pkg::OFS_MCU_CONTROL, got);
      chk8(got, 8'h20);
      wr(rst_pwr_pkg::OFS_MCU_CONTROL, 8'h40);
      rd(rst_pwr_pkg::OFS_MCU_CONTROL, got);
      chk8(got, 8'h40);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
